// File: rtl/io_channel_controller.v
`timescale 1ns/10ps
`default_nettype none
`include "io_channel_controller_space_regs.vh"
module io_channel_controller
(
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // configuration
  input  wire        buffered_mode,
  input  wire [15:0] range_lo,
  input  wire [15:0] range_hi,
  input  wire [63:0] chan_key,
  input  wire [15:0] chan_dma_src,
  input  wire [15:0] chan_buf_en,
  input  wire [63:0] chan_buf_id,
  // page map load
  input  wire        pmt_we,
  input  wire [5:0]  pmt_windex,
  input  wire        pmt_wvalid,
  input  wire [3:0]  pmt_wkey,
  input  wire        pmt_wwrite,
  input  wire [19:0] pmt_wrpn,
  // tag table load and channel start
  input  wire        tag_we,
  input  wire [3:0]  tag_widx,
  input  wire [31:0] tag_waddr,
  input  wire [15:0] tag_wcount,
  input  wire [3:0]  tag_wnext,
  input  wire        tag_wlast,
  input  wire        tag_start,
  input  wire [3:0]  tag_start_chan,
  input  wire [3:0]  tag_start_idx,
  // processor request
  input  wire        cpu_req,
  input  wire        cpu_ctl_space,
  input  wire        cpu_cond_user,
  input  wire [3:0]  cpu_key,
  input  wire        cpu_write,
  input  wire [31:0] cpu_addr,
  // bus master request
  input  wire        bm_req,
  input  wire [3:0]  bm_channel,
  input  wire        bm_write,
  input  wire [31:0] bm_addr,
  // dma slave request
  input  wire        dma_req,
  input  wire [3:0]  dma_channel,
  input  wire        dma_write,
  input  wire [2:0]  dma_size,
  input  wire [5:0]  dma_page,
  input  wire [11:0] dma_offset,
  // violation status
  input  wire        vio_clear,
  // control register space
  output reg         creg_req,
  output reg  [15:0] creg_addr,
  output reg         creg_write,
  // i/o bus
  output reg         bus_io_req,
  output reg         bus_mem_req,
  output reg         bus_write,
  output reg  [31:0] bus_addr,
  // system memory
  output reg         sys_req,
  output reg         sys_write,
  output reg  [31:0] sys_addr,
  output reg         sys_from_dma,
  output reg         sys_buffered,
  output reg  [3:0]  sys_buf_id,
  output reg         cache_inval,
  // request answers
  output reg         cpu_deny,
  output reg         bm_claim,
  output reg         dma_ack,
  output reg         dma_end,
  // violation status
  output reg         vio_flag,
  output reg  [2:0]  vio_code,
  output reg  [31:0] vio_addr
);
  // channel field pickers
  function [3:0] nib;
    input [63:0] v;
    input [3:0]  n;
    begin
      nib = v[n*4 +: 4];
    end
  endfunction

  // bus page inside the mapped window
  function in_window;
    input [31:0] a;
    begin
      in_window = (a[31:18] == `PMT_WINDOW_BASE);
    end
  endfunction

  // key and write-permission check of an entry
  function key_ok;
    input [25:0] e;
    input [3:0]  k;
    input        wr;
    begin
      key_ok = e[25] & (e[23:20] == `KEY_OPEN | e[23:20] == k) & (~wr | e[24]);
    end
  endfunction

  wire [25:0] ent_bm;
  wire [25:0] ent_b;
  wire [31:0] tag_addr;
  wire        tag_last;
  reg         next_step;
  reg  [5:0]  index_b;

  // processor and dma share lookup port b; dma only when processor idle
  always @*
  begin
    index_b = cpu_req ? cpu_addr[17:12] : dma_page;
  end

  page_map_table u_pmt
  (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (pmt_we),
    .windex  (pmt_windex),
    .wvalid  (pmt_wvalid),
    .wkey    (pmt_wkey),
    .wwrite  (pmt_wwrite),
    .wrpn    (pmt_wrpn),
    .index_a (bm_addr[17:12]),
    .index_b (index_b),
    .entry_a (ent_bm),
    .entry_b (ent_b)
  );

  dma_tag_table u_tag
  (
    .clk        (clk),
    .reset_n    (reset_n),
    .tag_we     (tag_we),
    .tag_widx   (tag_widx),
    .tag_waddr  (tag_waddr),
    .tag_wcount (tag_wcount),
    .tag_wnext  (tag_wnext),
    .tag_wlast  (tag_wlast),
    .start      (tag_start),
    .start_chan (tag_start_chan),
    .start_idx  (tag_start_idx),
    .step       (next_step),
    .chan       (dma_channel),
    .size       (dma_size),
    .addr       (tag_addr),
    .last       (tag_last)
  );

  // processor decode
  wire cpu_is_io  = (cpu_addr[31:16] == 16'h0000);
  wire cpu_is_mem = ~cpu_is_io;
  wire cpu_rng_ok = (cpu_addr[15:0] >= range_lo) & (cpu_addr[15:0] <= range_hi);
  wire cpu_key_ok = in_window(cpu_addr) & key_ok(ent_b, cpu_key, cpu_write);
  wire cpu_io_bad = cpu_cond_user & cpu_is_io & ~cpu_rng_ok;
  wire cpu_mem_bad = cpu_cond_user & cpu_is_mem & ~cpu_key_ok;
  wire cpu_bad = cpu_req & ~cpu_ctl_space & (cpu_io_bad | cpu_mem_bad);
  wire cpu_bus = cpu_req & ~cpu_ctl_space & ~cpu_bad;

  // bus master decode: window hits that pass channel and key checks are claimed, others stay on the bus
  wire bm_hit = bm_req & in_window(bm_addr);
  wire bm_chan_bad = (bm_channel == `CPU_CHANNEL);
  wire bm_key_good = key_ok(ent_bm, nib(chan_key, bm_channel), bm_write);
  wire bm_bad = bm_hit & (bm_chan_bad | ~bm_key_good);
  wire bm_go = bm_hit & ~bm_bad;

  // dma decode; channel 15 never runs dma, bus masters own the port first
  wire dma_pm = chan_dma_src[dma_channel];
  wire dma_chan_bad = (dma_channel == `CPU_CHANNEL);
  wire dma_key_good = key_ok(ent_b, nib(chan_key, dma_channel), dma_write);
  wire dma_turn = dma_req & ~bm_hit & ~cpu_req;
  wire dma_bad = dma_turn & (dma_chan_bad | (dma_pm & ~dma_key_good));
  wire dma_go = dma_turn & ~dma_bad;
  wire [31:0] dma_pm_addr = {ent_b[19:0], dma_offset};
  wire [31:0] dma_addr = dma_pm ? dma_pm_addr : tag_addr;

  // tag pointer advances only on a granted tag-sourced beat
  always @*
  begin
    next_step = dma_go & ~dma_pm;
  end

  // violation source in fixed priority: processor, bus master, dma
  reg [2:0]  next_code;
  reg [31:0] next_vaddr;
  always @*
  begin
    next_code = `VIO_NONE;
    next_vaddr = 32'h0000_0000;
    if (cpu_bad)
    begin
      next_code = cpu_io_bad ? `VIO_IO_RANGE : `VIO_CPU_KEY;
      next_vaddr = cpu_addr;
    end
    else if (bm_bad)
    begin
      next_code = bm_chan_bad ? `VIO_BM_CHANNEL : `VIO_BM_KEY;
      next_vaddr = bm_addr;
    end
    else if (dma_bad)
    begin
      next_code = dma_chan_bad ? `VIO_DMA_CHANNEL : `VIO_DMA_KEY;
      next_vaddr = {26'h000_0000, dma_page};
    end
  end

  // private control space: only the processor path reaches it
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      creg_req   <= 1'b0;
      creg_addr  <= 16'h0000;
      creg_write <= 1'b0;
    end
    else
    begin
      creg_req   <= cpu_req & cpu_ctl_space;
      creg_addr  <= cpu_addr[15:0];
      creg_write <= cpu_write;
    end
  end

  // i/o bus side; i/o cycles drive zeros on the ignored upper lines
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_io_req  <= 1'b0;
      bus_mem_req <= 1'b0;
      bus_write   <= 1'b0;
      bus_addr    <= 32'h0000_0000;
      cpu_deny    <= 1'b0;
    end
    else
    begin
      bus_io_req  <= cpu_bus & cpu_is_io;
      bus_mem_req <= cpu_bus & cpu_is_mem;
      bus_write   <= cpu_write;
      if (cpu_is_io)
        bus_addr <= {16'h0000, cpu_addr[15:0]};
      else
        bus_addr <= cpu_addr;
      cpu_deny    <= cpu_bad;
    end
  end

  // system memory port; no cache or frame table update path exists
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sys_req      <= 1'b0;
      sys_write    <= 1'b0;
      sys_addr     <= 32'h0000_0000;
      sys_from_dma <= 1'b0;
      sys_buffered <= 1'b0;
      sys_buf_id   <= 4'h0;
      cache_inval  <= 1'b0;
      bm_claim     <= 1'b0;
      dma_ack      <= 1'b0;
      dma_end      <= 1'b0;
    end
    else
    begin
      sys_req      <= bm_go | dma_go;
      bm_claim     <= bm_go;
      dma_ack      <= dma_go;
      dma_end      <= dma_go & ~dma_pm & tag_last;
      sys_from_dma <= ~bm_go;
      if (bm_go)
      begin
        sys_write    <= bm_write;
        sys_addr     <= {ent_bm[19:0], bm_addr[11:0]};
        sys_buffered <= buffered_mode & chan_buf_en[bm_channel];
        sys_buf_id   <= nib(chan_buf_id, bm_channel);
      end
      else
      begin
        sys_write    <= dma_write;
        sys_addr     <= dma_addr;
        sys_buffered <= buffered_mode & chan_buf_en[dma_channel];
        sys_buf_id   <= nib(chan_buf_id, dma_channel);
      end
      // snoop only unbuffered writes; buffered coherency is software's job
      cache_inval  <= ~buffered_mode & ((bm_go & bm_write) | (dma_go & dma_write));
    end
  end

  // sticky violation record; a new fault beats a same-cycle clear
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vio_flag <= 1'b0;
      vio_code <= `VIO_NONE;
      vio_addr <= 32'h0000_0000;
    end
    else if (next_code != `VIO_NONE)
    begin
      vio_flag <= 1'b1;
      vio_code <= next_code;
      vio_addr <= next_vaddr;
    end
    else if (vio_clear)
    begin
      vio_flag <= 1'b0;
      vio_code <= `VIO_NONE;
    end
  end
endmodule // io_channel_controller
`default_nettype wire

// File: rtl/io_channel_controller_space_regs.vh
// Operation
// - Sixteen channels; channel 15 belongs to processor loads and stores only.
// - Bus address is 32 bits; I/O and memory spaces share 4G range.
// - Processor access below 64K decodes as bus I/O using 16 address bits.
// - Processor access at or above 64K decodes as bus memory.
// - Conditional-user bus I/O access allowed only inside the authorized range.
// - Conditional-user bus memory access allowed only if page-map entry key authorizes.
// - Bus memory references map to system memory via page map, checked, transparent.
// - Accesses to memory or I/O on the bus itself are never checked.
// - DMA slave addresses may come from a chaining tag table, byte granular.
// - DMA slave address may be real page number joined with an offset.
// - I/O accesses to system memory never update cache or page frame table.
// - Unbuffered mode keeps cache coherent in hardware; buffered leaves it to software.
// - Buffered mode offers up to sixteen buffers, each bound to a channel.
// - Processor bus memory accesses go straight to the bus, bypassing cache.
// - Control registers reachable only by processor loads and stores, private space.
`ifndef IO_CHANNEL_CONTROLLER_SPACE_REGS_VH
`define IO_CHANNEL_CONTROLLER_SPACE_REGS_VH

`define CPU_CHANNEL      4'hF
`define IO_SPACE_TOP     16'hFFFF
`define PAGE_BITS        12
`define PMT_INDEX_W      6
`define PMT_WINDOW_BASE  14'h0040
`define PMT_RPN_W        20
`define KEY_OPEN         4'h0

`define VIO_NONE         3'h0
`define VIO_IO_RANGE     3'h1
`define VIO_CPU_KEY      3'h2
`define VIO_BM_KEY       3'h3
`define VIO_BM_CHANNEL   3'h4
`define VIO_DMA_KEY      3'h5
`define VIO_DMA_CHANNEL  3'h6

`endif

// File: rtl/page_map_table.v
`timescale 1ns/10ps
`default_nettype none
`include "io_channel_controller_space_regs.vh"
module page_map_table
(
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // entry load
  input  wire        we,
  input  wire [5:0]  windex,
  input  wire        wvalid,
  input  wire [3:0]  wkey,
  input  wire        wwrite,
  input  wire [19:0] wrpn,
  // lookup ports
  input  wire [5:0]  index_a,
  input  wire [5:0]  index_b,
  output wire [25:0] entry_a,
  output wire [25:0] entry_b
);
  // entry layout: valid, write allowed, key, real page number
  reg [25:0] entry [0:63];
  integer    i;

  // entries clear at reset so no stale mapping leaks between tasks
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < 64; i = i + 1)
        entry[i] <= 26'h000_0000;
    end
    else if (we)
    begin
      entry[windex] <= {wvalid, wwrite, wkey, wrpn};
    end
  end

  // two read ports: bus-master path and processor/dma path
  assign entry_a = entry[index_a];
  assign entry_b = entry[index_b];
endmodule // page_map_table
`default_nettype wire

// File: rtl/dma_tag_table.v
`timescale 1ns/10ps
`default_nettype none
`include "io_channel_controller_space_regs.vh"
module dma_tag_table
(
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // tag load
  input  wire        tag_we,
  input  wire [3:0]  tag_widx,
  input  wire [31:0] tag_waddr,
  input  wire [15:0] tag_wcount,
  input  wire [3:0]  tag_wnext,
  input  wire        tag_wlast,
  // channel start
  input  wire        start,
  input  wire [3:0]  start_chan,
  input  wire [3:0]  start_idx,
  // transfer step
  input  wire        step,
  input  wire [3:0]  chan,
  input  wire [2:0]  size,
  output wire [31:0] addr,
  output wire        last
);
  // tag: address, byte count, link, end of chain
  reg [31:0] tag_addr  [0:15];
  reg [15:0] tag_count [0:15];
  reg [3:0]  tag_next  [0:15];
  reg        tag_last  [0:15];
  // per-channel running position
  reg [31:0] cur_addr  [0:15];
  reg [15:0] cur_count [0:15];
  reg [3:0]  cur_tag   [0:15];
  integer    i;
  wire [15:0] left = cur_count[chan];
  wire [15:0] nbytes = {13'h0000, size};
  wire        exhaust = (left <= nbytes);
  wire [3:0]  nxt = tag_next[cur_tag[chan]];

  assign addr = cur_addr[chan];
  assign last = exhaust & tag_last[cur_tag[chan]];

  // byte-granular advance; chain to next tag when count runs out
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < 16; i = i + 1)
      begin
        tag_addr[i]  <= 32'h0000_0000;
        tag_count[i] <= 16'h0000;
        tag_next[i]  <= 4'h0;
        tag_last[i]  <= 1'b1;
        cur_addr[i]  <= 32'h0000_0000;
        cur_count[i] <= 16'h0000;
        cur_tag[i]   <= 4'h0;
      end
    end
    else
    begin
      if (tag_we)
      begin
        tag_addr[tag_widx]  <= tag_waddr;
        tag_count[tag_widx] <= tag_wcount;
        tag_next[tag_widx]  <= tag_wnext;
        tag_last[tag_widx]  <= tag_wlast;
      end
      if (start)
      begin
        cur_tag[start_chan]   <= start_idx;
        cur_addr[start_chan]  <= tag_addr[start_idx];
        cur_count[start_chan] <= tag_count[start_idx];
      end
      // a start on another channel must not swallow this beat
      if (step && !(start && (start_chan == chan)))
      begin
        if (exhaust && !tag_last[cur_tag[chan]])
        begin
          cur_tag[chan]   <= nxt;
          cur_addr[chan]  <= tag_addr[nxt];
          cur_count[chan] <= tag_count[nxt];
        end
        else
        begin
          cur_addr[chan]  <= cur_addr[chan] + {29'h0000_0000, size};
          cur_count[chan] <= exhaust ? 16'h0000 : left - nbytes;
        end
      end
    end
  end
endmodule // dma_tag_table
`default_nettype wire

// File: bench/space_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module space_control_checker
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // requests
  input wire logic        buffered_mode,
  input wire logic [15:0] range_lo,
  input wire logic [15:0] range_hi,
  input wire logic        cpu_req,
  input wire logic        cpu_ctl_space,
  input wire logic        cpu_cond_user,
  input wire logic [31:0] cpu_addr,
  input wire logic        bm_req,
  input wire logic [3:0]  bm_channel,
  input wire logic [31:0] bm_addr,
  // answers
  input wire logic        creg_req,
  input wire logic        bus_io_req,
  input wire logic        bus_mem_req,
  input wire logic [31:0] bus_addr,
  input wire logic        sys_req,
  input wire logic        sys_write,
  input wire logic        cache_inval,
  input wire logic        cpu_deny,
  input wire logic        bm_claim,
  input wire logic        vio_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // request shapes used by the properties below
  sequence s_plain_cpu;
    cpu_req && !cpu_ctl_space && !cpu_cond_user;
  endsequence
  sequence s_bm_window;
    bm_req && bm_addr[31:18] == 14'h0040;
  endsequence

  a_io_decode: assert property (s_plain_cpu ##0 cpu_addr[31:16] == 16'h0000 |=>
    bus_io_req && bus_addr == ($past(cpu_addr) & 32'h0000_FFFF)) else $error("io decode");
  a_mem_decode: assert property (s_plain_cpu ##0 cpu_addr[31:16] != 16'h0000 |=>
    bus_mem_req && !bus_io_req && bus_addr == $past(cpu_addr)) else $error("mem decode");
  a_ctl_private: assert property (cpu_req && cpu_ctl_space && !cpu_cond_user |=>
    creg_req && !bus_io_req && !bus_mem_req) else $error("control space leak");
  a_one_answer: assert property (cpu_req |=>
    $onehot({creg_req, bus_io_req, bus_mem_req, cpu_deny})) else $error("answer count");
  a_io_range: assert property (cpu_req && !cpu_ctl_space && cpu_cond_user
    && cpu_addr[31:16] == 16'h0000 && (cpu_addr[15:0] < range_lo || cpu_addr[15:0] > range_hi)
    |=> cpu_deny && !bus_io_req) else $error("range not enforced");
  a_io_upper: assert property (bus_io_req |-> bus_addr[31:16] == 16'h0000)
    else $error("io upper bits");
  a_deny_record: assert property (cpu_deny |-> vio_flag && !bus_io_req && !bus_mem_req)
    else $error("deny not recorded");
  a_bm_onbus: assert property (bm_req && bm_addr[31:18] != 14'h0040 |=> !bm_claim)
    else $error("on-bus access claimed");
  a_bm_cpu_chan: assert property (s_bm_window ##0 bm_channel == 4'hF |=>
    !bm_claim && vio_flag) else $error("channel 15 master");
  a_claim_sys: assert property (bm_claim |-> sys_req && $past(bm_req))
    else $error("claim without memory");
  a_inval_mode: assert property (cache_inval |->
    sys_req && sys_write && !$past(buffered_mode)) else $error("invalidate misuse");
endmodule // space_control_checker

bind io_channel_controller space_control_checker u_checker
(
  .clk, .reset_n, .buffered_mode, .range_lo, .range_hi, .cpu_req, .cpu_ctl_space,
  .cpu_cond_user, .cpu_addr, .bm_req, .bm_channel, .bm_addr, .creg_req, .bus_io_req,
  .bus_mem_req, .bus_addr, .sys_req, .sys_write, .cache_inval, .cpu_deny, .bm_claim, .vio_flag
);
`default_nettype wire

// File: bench/bus_requester_model.sv
`timescale 1ns/10ps
`default_nettype none
module bus_requester_model
(
  // clock
  input  wire logic        clk,
  // bus master side
  output var  logic        bm_req,
  output var  logic [3:0]  bm_channel,
  output var  logic        bm_write,
  output var  logic [31:0] bm_addr,
  // dma slave side
  output var  logic        dma_req,
  output var  logic [3:0]  dma_channel,
  output var  logic        dma_write,
  output var  logic [2:0]  dma_size,
  output var  logic [5:0]  dma_page,
  output var  logic [11:0] dma_offset
);
  // idle at time zero
  initial
  begin
    {bm_req, bm_channel, bm_write, bm_addr} = '0;
    {dma_req, dma_channel, dma_write, dma_size, dma_page, dma_offset} = '0;
  end

  // one master reference; released lines stop showing the old address
  task bm_ref(input logic [3:0] ch, input logic [31:0] a, input logic w);
    @(posedge clk);
    bm_req     <= 1'b1;
    bm_channel <= ch;
    bm_write   <= w;
    bm_addr    <= a;
    @(posedge clk);
    bm_req  <= 1'b0;
    bm_addr <= ~a;
    #1;
  endtask

  // one dma slave beat of 0..7 bytes
  task dma_ref(input logic [3:0] ch, input logic w, input logic [2:0] sz,
               input logic [5:0] pg, input logic [11:0] off);
    @(posedge clk);
    dma_req     <= 1'b1;
    dma_channel <= ch;
    dma_write   <= w;
    dma_size    <= sz;
    dma_page    <= pg;
    dma_offset  <= off;
    @(posedge clk);
    dma_req    <= 1'b0;
    dma_offset <= ~off;
    #1;
  endtask
endmodule // bus_requester_model
`default_nettype wire

// File: bench/io_channel_controller_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module io_channel_controller_tb_top;
  logic        clk, reset_n, buffered_mode, vio_clear, pmt_we, pmt_wvalid, pmt_wwrite;
  logic        tag_we, tag_wlast, tag_start, cpu_req, cpu_ctl_space, cpu_cond_user, cpu_write;
  logic [15:0] range_lo, range_hi, chan_dma_src, chan_buf_en, tag_wcount;
  logic [63:0] chan_key, chan_buf_id;
  logic [5:0]  pmt_windex;
  logic [3:0]  pmt_wkey, tag_widx, tag_wnext, tag_start_chan, tag_start_idx, cpu_key;
  logic [19:0] pmt_wrpn;
  logic [31:0] tag_waddr, cpu_addr;
  wire         bm_req, bm_write, dma_req, dma_write;
  wire  [3:0]  bm_channel, dma_channel, sys_buf_id;
  wire  [31:0] bm_addr, bus_addr, sys_addr, vio_addr;
  wire  [2:0]  dma_size, vio_code;
  wire  [5:0]  dma_page;
  wire  [11:0] dma_offset;
  wire  [15:0] creg_addr;
  wire         creg_req, creg_write, bus_io_req, bus_mem_req, bus_write, sys_req, sys_write;
  wire         sys_from_dma, sys_buffered, cache_inval, cpu_deny, bm_claim, dma_ack;
  wire         dma_end, vio_flag;
  int          bad_count = 0;
  int          n_checks = 0;

  io_channel_controller uut
  (
    .clk, .reset_n, .buffered_mode, .range_lo, .range_hi, .chan_key, .chan_dma_src,
    .chan_buf_en, .chan_buf_id, .pmt_we, .pmt_windex,
    .pmt_wvalid, .pmt_wkey, .pmt_wwrite, .pmt_wrpn, .tag_we, .tag_widx, .tag_waddr,
    .tag_wcount, .tag_wnext, .tag_wlast, .tag_start, .tag_start_chan, .tag_start_idx,
    .cpu_req, .cpu_ctl_space, .cpu_cond_user, .cpu_key, .cpu_write, .cpu_addr,
    .bm_req, .bm_channel, .bm_write, .bm_addr, .dma_req, .dma_channel, .dma_write, .dma_size,
    .dma_page, .dma_offset, .vio_clear, .creg_req, .creg_addr, .creg_write, .bus_io_req,
    .bus_mem_req, .bus_write, .bus_addr, .sys_req, .sys_write, .sys_addr, .sys_from_dma,
    .sys_buffered, .sys_buf_id, .cache_inval, .cpu_deny, .bm_claim, .dma_ack, .dma_end,
    .vio_flag, .vio_code, .vio_addr
  );

  bus_requester_model far
  (
    .clk, .bm_req, .bm_channel, .bm_write, .bm_addr, .dma_req, .dma_channel, .dma_write,
    .dma_size, .dma_page, .dma_offset
  );

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // processor access; answer is looked at in the cycle after the request stands
  task cpu_op(input logic ctl, input logic cond, input logic w, input logic [3:0] k,
              input logic [31:0] a);
    @(posedge clk);
    cpu_req       <= 1'b1;
    cpu_ctl_space <= ctl;
    cpu_cond_user <= cond;
    cpu_write     <= w;
    cpu_key       <= k;
    cpu_addr      <= a;
    @(posedge clk);
    cpu_req <= 1'b0;
    #1;
  endtask

  // one page map entry, always valid: write allowed, key, real page number
  task pmt_put(input logic [5:0] idx, input logic wr, input logic [3:0] k,
               input logic [19:0] real_page_number);
    @(posedge clk);
    pmt_we     <= 1'b1;
    pmt_wvalid <= 1'b1;
    pmt_wwrite <= wr;
    pmt_windex <= idx;
    pmt_wkey   <= k;
    pmt_wrpn   <= real_page_number;
    @(posedge clk);
    pmt_we <= 1'b0;
  endtask

  // one tag: start address, byte count, link, end of chain
  task tag_put(input logic [3:0] idx, input logic [31:0] a, input logic [15:0] n,
               input logic [3:0] nx, input logic lst);
    @(posedge clk);
    tag_we     <= 1'b1;
    tag_widx   <= idx;
    tag_waddr  <= a;
    tag_wcount <= n;
    tag_wnext  <= nx;
    tag_wlast  <= lst;
    @(posedge clk);
    tag_we <= 1'b0;
  endtask

  task t_cpu_decode();
    cpu_op(1'b0, 1'b0, 1'b1, 4'h0, 32'h0000_FFFF);
    chk(bus_io_req, 1'b1);
    chk(bus_addr, 32'h0000_FFFF);
    chk(bus_write, 1'b1);
    cpu_op(1'b0, 1'b0, 1'b0, 4'h0, 32'h0001_0000);
    chk(bus_mem_req, 1'b1);
    chk(bus_addr, 32'h0001_0000);
    chk(bus_write, 1'b0);
    cpu_op(1'b1, 1'b0, 1'b1, 4'h0, 32'h0000_0008);
    chk(creg_req, 1'b1);
    chk(bus_io_req | bus_mem_req, 1'b0);
    chk({creg_write, creg_addr}, 17'h1_0008);
    $display("t_cpu_decode done");
  endtask

  task t_bus_master();
    pmt_put(6'h01, 1'b1, 4'h0, 20'h0_ABCD);
    pmt_put(6'h02, 1'b0, 4'h5, 20'h0_1234);
    far.bm_ref(4'h3, 32'h0100_1ABC, 1'b1);
    chk(bm_claim & sys_req, 1'b1);
    chk(sys_addr, 32'h0ABC_DABC);
    chk({sys_write, cache_inval}, 2'h3);
    far.bm_ref(4'h3, 32'h0200_0000, 1'b0);
    chk({bm_claim, sys_req, vio_flag}, 3'h0);
    far.bm_ref(4'h3, 32'h0100_2000, 1'b0);
    chk({bm_claim, vio_code}, 4'h3);
    far.bm_ref(4'hF, 32'h0100_1000, 1'b0);
    chk(bm_claim, 1'b0);
    chk(vio_code, 3'h4);
    chk(vio_addr, 32'h0100_1000);
    $display("t_bus_master done");
  endtask

  task t_cpu_protect();
    cpu_op(1'b0, 1'b1, 1'b0, 4'h0, 32'h0000_0200);
    chk(cpu_deny, 1'b1);
    chk({vio_flag, vio_code}, 4'h9);
    @(posedge clk);
    vio_clear <= 1'b1;
    @(posedge clk);
    vio_clear <= 1'b0;
    #1;
    chk(vio_flag, 1'b0);
    cpu_op(1'b0, 1'b1, 1'b0, 4'h0, 32'h0000_01FF);
    chk(bus_io_req, 1'b1);
    cpu_op(1'b0, 1'b1, 1'b0, 4'h0, 32'h0101_4000);
    chk({cpu_deny, vio_code}, 4'hA);
    cpu_op(1'b0, 1'b1, 1'b0, 4'h0, 32'h0100_1000);
    chk(bus_mem_req, 1'b1);
    cpu_op(1'b0, 1'b1, 1'b0, 4'h5, 32'h0100_2000);
    chk(bus_mem_req, 1'b1);
    cpu_op(1'b0, 1'b1, 1'b1, 4'h5, 32'h0100_2000);
    chk(cpu_deny, 1'b1);
    cpu_op(1'b0, 1'b1, 1'b0, 4'h6, 32'h0100_2000);
    chk(cpu_deny, 1'b1);
    $display("t_cpu_protect done");
  endtask

  task t_dma_page();
    @(posedge clk);
    chan_dma_src <= 16'h0004;
    chan_buf_en  <= 16'h0004;
    chan_buf_id  <= 64'h0000_0000_0000_0900;
    far.dma_ref(4'h2, 1'b1, 3'h4, 6'h01, 12'h010);
    chk({dma_ack, sys_from_dma, cache_inval}, 3'h7);
    chk(sys_addr, 32'h0ABC_D010);
    chk(sys_buffered, 1'b0);
    @(posedge clk);
    buffered_mode <= 1'b1;
    far.dma_ref(4'h2, 1'b1, 3'h4, 6'h01, 12'h020);
    chk({dma_ack, cache_inval}, 2'h2);
    chk({sys_buffered, sys_buf_id}, 5'h19);
    far.dma_ref(4'h2, 1'b0, 3'h1, 6'h02, 12'h000);
    chk({dma_ack, vio_code}, 4'h5);
    chk(vio_addr, 32'h0000_0002);
    far.dma_ref(4'hF, 1'b0, 3'h1, 6'h01, 12'h000);
    chk({dma_ack, vio_code}, 4'h6);
    $display("t_dma_page done");
  endtask

  task t_dma_tag();
    tag_put(4'h3, 32'h0000_2000, 16'h0008, 4'h0, 1'b1);
    tag_put(4'h6, 32'h0000_5000, 16'h0002, 4'h7, 1'b0);
    tag_put(4'h7, 32'h0000_3000, 16'h0001, 4'h0, 1'b1);
    @(posedge clk);
    tag_start      <= 1'b1;
    tag_start_chan <= 4'h5;
    tag_start_idx  <= 4'h3;
    @(posedge clk);
    tag_start_chan <= 4'h4;
    tag_start_idx  <= 4'h6;
    @(posedge clk);
    tag_start <= 1'b0;
    far.dma_ref(4'h5, 1'b0, 3'h3, 6'h00, 12'h000);
    chk({dma_ack, dma_end}, 2'h2);
    chk(sys_addr, 32'h0000_2000);
    chk(cache_inval, 1'b0);
    far.dma_ref(4'h5, 1'b0, 3'h4, 6'h00, 12'h000);
    chk({dma_ack, dma_end}, 2'h2);
    chk(sys_addr, 32'h0000_2003);
    far.dma_ref(4'h5, 1'b0, 3'h1, 6'h00, 12'h000);
    chk({dma_ack, dma_end}, 2'h3);
    chk(sys_addr, 32'h0000_2007);
    far.dma_ref(4'h4, 1'b0, 3'h2, 6'h00, 12'h000);
    chk({dma_ack, dma_end}, 2'h2);
    chk(sys_addr, 32'h0000_5000);
    far.dma_ref(4'h4, 1'b0, 3'h1, 6'h00, 12'h000);
    chk({dma_ack, dma_end}, 2'h3);
    chk(sys_addr, 32'h0000_3000);
    $display("t_dma_tag done");
  endtask

  // main sequence
  initial
  begin
    {reset_n, buffered_mode, vio_clear, chan_dma_src, chan_key, pmt_we, pmt_wvalid} = '0;
    {pmt_wwrite, pmt_windex, pmt_wkey, pmt_wrpn, tag_we, tag_wlast, tag_start} = '0;
    {tag_widx, tag_start_chan, tag_start_idx, tag_waddr, tag_wcount} = '0;
    {cpu_req, cpu_ctl_space, cpu_cond_user, cpu_addr} = '0;
    {chan_buf_en, chan_buf_id, tag_wnext, cpu_key, cpu_write} = '0;
    range_lo = 16'h0100;
    range_hi = 16'h01FF;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_cpu_decode();
    t_bus_master();
    t_cpu_protect();
    t_dma_page();
    t_dma_tag();
    conclude();
  end

  // hang guard
  initial
  begin
    repeat (4000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule // io_channel_controller_tb_top
`default_nettype wire
